// [design/cvt_trim_regs.sv]
`timescale 1ns/1ps
// ************************************************
// calibration vector access and factory trims
// ************************************************

// Contract
// - enable bit gates vector data port access
// - enable register resets to all zeros
// - successive reads return vector bytes in order
// - successive writes load vector bytes in order
// - incomplete sequence leaves vector marked invalid
// - gain trim a loads factory value
// - gain trim b loads factory value
// - reference trim four bits out, upper bits stored and read back
// - termination trim a loads factory value
module cvt_trim_regs (
	// clock, reset, enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [cvt_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [cvt_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [cvt_pkg::BE_W-1:0] avs_byteenable,
	output logic [cvt_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// pins from the calibration engine and fuses
	input wire logic calibration_halted_status,
	input wire logic [cvt_pkg::FACT_W-1:0] factory_trims,
	// trim values to the analog side
	output logic [cvt_pkg::BYTE_W-1:0] gain_adjust_first_channel,
	output logic [cvt_pkg::BYTE_W-1:0] gain_adjust_second_channel,
	output logic [cvt_pkg::REF_W-1:0] reference_voltage_adjust,
	output logic [cvt_pkg::BYTE_W-1:0] input_termination_adjust_first,
	// vector state to the calibration engine
	output logic calib_access_enable,
	output logic calib_vector_valid
);

	// ************************************************
	// state
	// ************************************************

	// fuse bundle split: two gains on top, then reference, termination
	localparam int GAIN_LO = cvt_pkg::FACT_W - 2 * cvt_pkg::BYTE_W;
	localparam int REF_HI = GAIN_LO - 1;
	localparam int STAGE_MID = cvt_pkg::SYNC_N - 2;
	localparam int STAGE_LAST = cvt_pkg::SYNC_N - 1;

	// a vector read needs one more state for the buffer hop
	typedef enum logic [1:0] {
		CVT_IDLE,
		CVT_FETCH,
		CVT_ACK
	} cvt_fsm_t;

	// all state in one record, so ce freezes every field at once
	typedef struct packed {
		cvt_fsm_t fsm;
		logic waitrequest;
		logic [cvt_pkg::DATA_W-1:0] rdata;
		logic [cvt_pkg::BYTE_W-1:0] en_reg;
		logic [cvt_pkg::BYTE_W-1:0] gain_a;
		logic [cvt_pkg::BYTE_W-1:0] gain_b;
		logic [cvt_pkg::BYTE_W-1:0] ref_reg;
		logic [cvt_pkg::BYTE_W-1:0] term_a;
		logic [cvt_pkg::IDX_W-1:0] idx;
		logic vec_valid;
		logic misuse;
		logic [cvt_pkg::SYNC_N-1:0] halt_sync;
		logic halted;
		logic [cvt_pkg::FACT_W-1:0] fact_s1;
		logic [cvt_pkg::FACT_W-1:0] fact_s2;
		logic [cvt_pkg::FACT_W-1:0] fact_s3;
		logic [cvt_pkg::SYNC_N-1:0] fact_fill;
		logic load_pending;
	} cvt_top_t;

	cvt_top_t st;
	cvt_top_t next_st;

	// ************************************************
	// carriers and sub-blocks
	// ************************************************

	// carriers to the store and through the buffer
	cvt_vec_if vec ();
	cvt_strm_if fill_s ();
	cvt_strm_if drain_s ();

	// the store reads combinationally at the live index
	cvt_vec_store u_store (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.vec(vec.store)
	);

	// read bytes pass the buffer, so a held-off read loses none
	cvt_buf2 u_buf (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.fill(fill_s.snk),
		.drain(drain_s.src)
	);

	// ************************************************
	// request decode
	// ************************************************

	// decoded request and the handshake into the sub-blocks
	logic req;
	logic wr_lane;
	logic [cvt_pkg::BYTE_W-1:0] wbyte;
	logic vec_hit;
	logic vec_open;
	logic vec_we;
	logic push_valid;
	logic pop_ready;
	logic [cvt_pkg::BYTE_W-1:0] rd_byte;

	// only the low lane carries register data
	assign req = avs_read || avs_write;
	assign wr_lane = avs_write && avs_byteenable[cvt_pkg::BE_LOW];
	assign wbyte = avs_writedata[cvt_pkg::BYTE_W-1:0];
	assign vec_hit = cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_VECTOR);
	// a closed port answers like a hole: zero, and the index stays
	assign vec_open = vec_hit && st.en_reg[cvt_pkg::EN_BIT];

	// store port follows the live byte index
	assign vec.idx = st.idx;
	assign vec.we = vec_we;
	assign vec.wdata = wbyte;
	assign fill_s.valid = push_valid;
	assign fill_s.data = vec.rdata;
	assign drain_s.ready = pop_ready;

	// register read mux; closed data port and holes read zero
	always_comb begin
		rd_byte = '0;
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_ENABLE)) begin
			rd_byte = st.en_reg;
		end
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_STATUS)) begin
			rd_byte[cvt_pkg::ST_HALT_BIT] = st.halted;
			rd_byte[cvt_pkg::ST_VALID_BIT] = st.vec_valid;
			rd_byte[cvt_pkg::ST_MISUSE_BIT] = st.misuse;
		end
		// index bytes let software see how far a pass got
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_INDEX_LO)) begin
			rd_byte = st.idx[cvt_pkg::BYTE_W-1:0];
		end
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_INDEX_HI)) begin
			rd_byte = cvt_pkg::BYTE_W'(
				st.idx[cvt_pkg::IDX_W-1:cvt_pkg::BYTE_W]);
		end
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_GAIN_A)) begin
			rd_byte = st.gain_a;
		end
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_GAIN_B)) begin
			rd_byte = st.gain_b;
		end
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_REF)) begin
			rd_byte = st.ref_reg;
		end
		if (cvt_pkg::cvt_hit(avs_address, cvt_pkg::OFS_TERM_A)) begin
			rd_byte = st.term_a;
		end
	end

	// ************************************************
	// next-state logic
	// ************************************************

	// one pass fills next_st from st and the bus
	always_comb begin
		next_st = st;
		vec_we = 1'b0;
		push_valid = 1'b0;
		pop_ready = 1'b0;

		// halted pin: three stages, taken once stages two and three agree;
		// a lone sample that differs from its neighbour is not taken
		next_st.halt_sync = {st.halt_sync[STAGE_MID:0],
			calibration_halted_status};
		if (st.halt_sync[STAGE_MID] == st.halt_sync[STAGE_LAST]) begin
			next_st.halted = st.halt_sync[STAGE_LAST];
		end

		// fuse bundle through the same three stages; the stages leave
		// reset equal at zero, so the fill mark waits for real samples
		next_st.fact_s1 = factory_trims;
		next_st.fact_s2 = st.fact_s1;
		next_st.fact_s3 = st.fact_s2;
		next_st.fact_fill = {st.fact_fill[STAGE_MID:0], 1'b1};

		// trims take the factory value once after reset
		if (st.load_pending && st.fact_fill[STAGE_LAST] &&
				st.fact_s2 == st.fact_s3) begin
			next_st.load_pending = 1'b0;
			{next_st.gain_a, next_st.gain_b} =
				st.fact_s3[cvt_pkg::FACT_W-1:GAIN_LO];
			next_st.ref_reg[cvt_pkg::REF_W-1:0] =
				st.fact_s3[REF_HI:cvt_pkg::BYTE_W];
			next_st.term_a = st.fact_s3[cvt_pkg::BYTE_W-1:0];
		end

		unique case (st.fsm)
			CVT_IDLE: begin
				if (req && vec_open) begin
					// a data access while calibration runs corrupts it
					// the flag is sticky; halting never blocks the access
					if (!st.halted) begin
						next_st.misuse = 1'b1;
					end
					// a fresh pass makes the vector invalid until done
					if (st.idx == '0) begin
						next_st.vec_valid = 1'b0;
					end
					if (avs_read) begin
						// the buffer stalls the read when it cannot take it
						if (fill_s.ready) begin
							push_valid = 1'b1;
							next_st.fsm = CVT_FETCH;
						end
					end else begin
						// the port is one byte, byte enables are not read
						vec_we = 1'b1;
						next_st.rdata = '0;
						next_st.waitrequest = 1'b0;
						next_st.fsm = CVT_ACK;
					end
					// every data byte moves the index on, wrapping at the end
					// a stalled read moves nothing, so a retry gets the same byte
					if (avs_write || fill_s.ready) begin
						if (st.idx == cvt_pkg::VEC_LAST) begin
							next_st.idx = '0;
							next_st.vec_valid = 1'b1;
						end else begin
							next_st.idx = st.idx + cvt_pkg::IDX_ONE;
						end
					end
				end else if (req) begin
					// plain registers answer in one cycle
					next_st.rdata = cvt_pkg::DATA_W'(rd_byte);
					next_st.waitrequest = 1'b0;
					next_st.fsm = CVT_ACK;
					if (wr_lane) begin
						if (cvt_pkg::cvt_hit(avs_address,
								cvt_pkg::OFS_ENABLE)) begin
							// reserved enable bits are plain storage
							next_st.en_reg = wbyte;
							// rising enable restarts the index; rewriting one
							// while enabled leaves the pass where it is
							if (!st.en_reg[cvt_pkg::EN_BIT] &&
									wbyte[cvt_pkg::EN_BIT]) begin
								next_st.idx = '0;
								next_st.vec_valid = 1'b0;
								next_st.misuse = 1'b0;
							end
						end
						if (cvt_pkg::cvt_hit(avs_address,
								cvt_pkg::OFS_GAIN_A)) begin
							next_st.gain_a = wbyte;
						end
						if (cvt_pkg::cvt_hit(avs_address,
								cvt_pkg::OFS_GAIN_B)) begin
							next_st.gain_b = wbyte;
						end
						if (cvt_pkg::cvt_hit(avs_address,
								cvt_pkg::OFS_REF)) begin
							next_st.ref_reg = wbyte;
						end
						if (cvt_pkg::cvt_hit(avs_address,
								cvt_pkg::OFS_TERM_A)) begin
							next_st.term_a = wbyte;
						end
					end
				end
			end
			CVT_FETCH: begin
				// hand the buffered byte to the bus
				// it was pushed one edge earlier, so it is always there
				pop_ready = 1'b1;
				if (drain_s.valid) begin
					next_st.rdata = cvt_pkg::DATA_W'(drain_s.data);
					next_st.waitrequest = 1'b0;
					next_st.fsm = CVT_ACK;
				end
			end
			CVT_ACK: begin
				// master drops the request after this edge
				// the gap cycle keeps back-to-back strobes apart
				next_st.waitrequest = 1'b1;
				next_st.fsm = CVT_IDLE;
			end
			default: begin
				// an illegal code returns to idle with the bus held off
				next_st.waitrequest = 1'b1;
				next_st.fsm = CVT_IDLE;
			end
		endcase
	end

	// ************************************************
	// state register
	// ************************************************

	// waitrequest idles high; trims wait for the fuse load
	// reset state is constants only, the factory load comes later
	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.fsm <= CVT_IDLE;
			st.waitrequest <= 1'b1;
			st.en_reg <= cvt_pkg::RST_ENABLE;
			st.ref_reg <= cvt_pkg::RST_REF;
			st.load_pending <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ************************************************
	// outputs, all straight from flip-flops
	// ************************************************

	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.waitrequest;
	assign gain_adjust_first_channel = st.gain_a;
	assign gain_adjust_second_channel = st.gain_b;
	assign reference_voltage_adjust = st.ref_reg[cvt_pkg::REF_W-1:0];
	assign input_termination_adjust_first = st.term_a;
	// only bit zero of the enable leaves; the rest is storage
	assign calib_access_enable = st.en_reg[cvt_pkg::EN_BIT];
	assign calib_vector_valid = st.vec_valid;

endmodule : cvt_trim_regs

// [design/cvt_pkg.sv]
// ************************************************
// shared constants for the trim and vector block
// ************************************************
package cvt_pkg;

	// bus geometry: byte address, one register per word
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int BE_W = 4;
	localparam int WORD_LSB = 2;
	localparam int REG_IDX_W = ADDR_W - WORD_LSB;

	// register indices, byte address is four times these
	localparam logic [REG_IDX_W-1:0] OFS_ENABLE = 8'h70;
	localparam logic [REG_IDX_W-1:0] OFS_VECTOR = 8'h71;
	localparam logic [REG_IDX_W-1:0] OFS_STATUS = 8'h72;
	localparam logic [REG_IDX_W-1:0] OFS_INDEX_LO = 8'h73;
	localparam logic [REG_IDX_W-1:0] OFS_INDEX_HI = 8'h74;
	localparam logic [REG_IDX_W-1:0] OFS_GAIN_A = 8'h7A;
	localparam logic [REG_IDX_W-1:0] OFS_GAIN_B = 8'h7B;
	localparam logic [REG_IDX_W-1:0] OFS_REF = 8'h7C;
	localparam logic [REG_IDX_W-1:0] OFS_TERM_A = 8'h7E;

	// field positions
	localparam int EN_BIT = 0;
	localparam int ST_HALT_BIT = 0;
	localparam int ST_VALID_BIT = 1;
	localparam int ST_MISUSE_BIT = 2;
	localparam int REF_W = 4;
	localparam int BE_LOW = 0;

	// reset values
	localparam logic [BYTE_W-1:0] RST_ENABLE = 8'h00;
	localparam logic [BYTE_W-1:0] RST_REF = 8'h00;

	// calibration vector
	localparam int VEC_LEN = 673;
	localparam int IDX_W = 10;
	localparam logic [IDX_W-1:0] VEC_LAST = IDX_W'(VEC_LEN - 1);
	localparam logic [IDX_W-1:0] IDX_ONE = 10'h001;

	// factory trim bundle: gain a, gain b, reference, termination a
	localparam int FACT_W = 3 * BYTE_W + REF_W;
	localparam int SYNC_N = 3;

	// register index match, used for every decode
	function automatic logic cvt_hit(logic [ADDR_W-1:0] a,
		logic [REG_IDX_W-1:0] ofs);
		return a[ADDR_W-1:WORD_LSB] == ofs;
	endfunction : cvt_hit

endpackage : cvt_pkg

// [design/cvt_ifs.sv]
`timescale 1ns/1ps
// ************************************************
// carriers between the block's own modules
// ************************************************

// indexed access to the vector store
interface cvt_vec_if;
	logic we;
	logic [cvt_pkg::IDX_W-1:0] idx;
	logic [cvt_pkg::BYTE_W-1:0] wdata;
	logic [cvt_pkg::BYTE_W-1:0] rdata;
	modport ctrl (output we, idx, wdata, input rdata);
	modport store (input we, idx, wdata, output rdata);
endinterface : cvt_vec_if

// byte stream with valid and ready
interface cvt_strm_if;
	logic valid;
	logic ready;
	logic [cvt_pkg::BYTE_W-1:0] data;
	modport src (output valid, data, input ready);
	modport snk (input valid, data, output ready);
endinterface : cvt_strm_if

// [design/cvt_vec_store.sv]
`timescale 1ns/1ps
// ************************************************
// calibration vector storage, one byte per index
// ************************************************
module cvt_vec_store (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// access port
	cvt_vec_if.store vec
);
	typedef struct packed {
		logic [cvt_pkg::VEC_LEN-1:0][cvt_pkg::BYTE_W-1:0] mem;
	} cvt_store_t;

	cvt_store_t st;
	cvt_store_t next_st;

	// out-of-range index reads zero and never writes
	always_comb begin
		next_st = st;
		vec.rdata = '0;
		if (vec.idx <= cvt_pkg::VEC_LAST) begin
			vec.rdata = st.mem[vec.idx];
			if (vec.we) begin
				next_st.mem[vec.idx] = vec.wdata;
			end
		end
	end

	// register the whole array
	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule : cvt_vec_store

// [design/cvt_buf2.sv]
`timescale 1ns/1ps
// ************************************************
// two-entry byte buffer with valid and ready
// ************************************************
module cvt_buf2 (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// filling side
	cvt_strm_if.snk fill,
	// draining side
	cvt_strm_if.src drain
);
	typedef struct packed {
		logic [1:0][cvt_pkg::BYTE_W-1:0] mem;
		logic wptr;
		logic rptr;
		logic [1:0] count;
	} cvt_buf_t;

	localparam logic [1:0] FULL = 2'h2;

	cvt_buf_t st;
	cvt_buf_t next_st;
	logic push;
	logic pop;

	// full and empty come straight from the count
	always_comb begin
		fill.ready = st.count != FULL;
		drain.valid = st.count != 2'h0;
		drain.data = st.mem[st.rptr];
		push = fill.valid && fill.ready;
		pop = drain.valid && drain.ready;
		next_st = st;
		if (push) begin
			next_st.mem[st.wptr] = fill.data;
			next_st.wptr = ~st.wptr;
		end
		if (pop) begin
			next_st.rptr = ~st.rptr;
		end
		if (push && !pop) begin
			next_st.count = st.count + 2'h1;
		end else if (pop && !push) begin
			next_st.count = st.count - 2'h1;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule : cvt_buf2

// [dv/cvt_trim_regs_assertions.sv]
`timescale 1ns/1ps
// ************************************************
// bus timing and register effects at the ports
// ************************************************
module cvt_trim_regs_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// trims and vector state
	input wire logic [7:0] gain_adjust_first_channel,
	input wire logic [7:0] gain_adjust_second_channel,
	input wire logic [3:0] reference_voltage_adjust,
	input wire logic [7:0] input_termination_adjust_first,
	input wire logic calib_access_enable,
	input wire logic calib_vector_valid
);
	default clocking @(posedge clock); endclocking
	// a frozen clock enable holds requests unanswered on purpose
	default disable iff (rst || !ce);
	// decoded register and accepted write
	logic [7:0] sel;
	logic wr_ack;
	assign sel = avs_address[9:2];
	assign wr_ack = avs_write && avs_byteenable[0] && !avs_waitrequest;
	a_reset_clears: assert property ($past(rst) |-> !calib_access_enable &&
		!calib_vector_valid && avs_waitrequest) else $error("reset state");
	a_answer_in_time: assert property ($rose(avs_read) || $rose(avs_write)
		|-> ##[1:2] !avs_waitrequest) else $error("late answer");
	a_answer_one_cycle: assert property (!avs_waitrequest |=>
		avs_waitrequest) else $error("answer too long");
	a_read_upper_zero: assert property (!avs_waitrequest |->
		avs_readdata[31:8] == 24'h000000) else $error("upper bits set");
	a_disabled_read_zero: assert property (avs_read && sel == 8'h71 &&
		!calib_access_enable && !avs_waitrequest |-> avs_readdata == 0)
		else $error("disabled port read");
	a_enable_follows: assert property (wr_ack && sel == 8'h70 |->
		calib_access_enable == avs_writedata[0]) else $error("enable");
	a_gain_a_write: assert property (wr_ack && sel == 8'h7A |->
		gain_adjust_first_channel == avs_writedata[7:0]) else $error("gain a");
	a_gain_b_write: assert property (wr_ack && sel == 8'h7B |->
		gain_adjust_second_channel == avs_writedata[7:0]) else $error("gain b");
	a_ref_write: assert property (wr_ack && sel == 8'h7C |->
		reference_voltage_adjust == avs_writedata[3:0]) else $error("ref");
	a_term_write: assert property (wr_ack && sel == 8'h7E |->
		input_termination_adjust_first == avs_writedata[7:0]) else $error("term");
	a_restart_clears: assert property (wr_ack && sel == 8'h70 &&
		avs_writedata[0] && !$past(calib_access_enable) |=> !calib_vector_valid)
		else $error("valid kept");
	// main scenarios
	c_vector_done: cover property ($rose(calib_vector_valid));
	c_vector_read: cover property (avs_read && sel == 8'h71 && !avs_waitrequest);
	c_enable_on: cover property ($rose(calib_access_enable));
endmodule : cvt_trim_regs_assertions

bind cvt_trim_regs cvt_trim_regs_assertions chk_u (.clock, .rst, .ce,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .gain_adjust_first_channel,
	.gain_adjust_second_channel, .reference_voltage_adjust,
	.input_termination_adjust_first, .calib_access_enable,
	.calib_vector_valid);

// [dv/tb.sv]
`timescale 1ns/1ps
// ************************************************
// self-checking bench for the trim register block
// ************************************************
module tb;
	// design inputs, all defined at time zero
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic halted = 1'b1;
	logic [27:0] fact = 28'h0000000;
	// design outputs
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] gain_a, gain_b, term_a;
	logic [3:0] ref_t;
	logic en_out, vec_valid;
	// bench state
	int num_errors = 0;
	int checks_done = 0;
	int seed = 25530;
	logic [7:0] vec [673];
	logic [31:0] rd;
	logic [7:0] w;
	logic [7:0] ofs;
	logic [31:0] exp_v;

	cvt_trim_regs dut_u (.clock(clock), .rst(rst), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.calibration_halted_status(halted), .factory_trims(fact),
		.gain_adjust_first_channel(gain_a),
		.gain_adjust_second_channel(gain_b),
		.reference_voltage_adjust(ref_t),
		.input_termination_adjust_first(term_a),
		.calib_access_enable(en_out), .calib_vector_valid(vec_valid));

	// free-running 100 MHz clock
	initial begin
		forever #5 clock = ~clock;
	end

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd, input logic [3:0] be);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		avs_byteenable <= be;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			num_errors++;
			close_out();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// one idle edge so no strobe is set twice in a time step
		@(posedge clock);
	endtask : bus

	// expected factory value of the trim register at idx
	function automatic logic [31:0] fact_of(input logic [7:0] idx);
		case (idx)
			8'h7A: return {24'h0, fact[27:20]};
			8'h7B: return {24'h0, fact[19:12]};
			8'h7C: return {28'h0, fact[11:8]};
			default: return {24'h0, fact[7:0]};
		endcase
	endfunction : fact_of

	function automatic logic [7:0] trim_ofs(input int i);
		return (i == 0) ? 8'h7A : (i == 1) ? 8'h7B : (i == 2) ? 8'h7C : 8'h7E;
	endfunction : trim_ofs

	// trim pin value seen for the register at idx
	function automatic logic [31:0] pin_of(input logic [7:0] idx);
		case (idx)
			8'h7A: return {24'h0, gain_a};
			8'h7B: return {24'h0, gain_b};
			8'h7C: return {28'h0, ref_t};
			default: return {24'h0, term_a};
		endcase
	endfunction : pin_of

	initial begin
		fact = 28'($random(seed));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		bus(1'b0, 8'h70, 0, 4'hF);
		check(rd, 32'h0);
		// factory values on pins and readback
		for (int i = 0; i < 4; i++) begin
			ofs = trim_ofs(i);
			bus(1'b0, ofs, 0, 4'hF);
			check(rd, fact_of(ofs));
			check(pin_of(ofs), fact_of(ofs));
		end
		// unmapped place and disabled vector port read as zero
		bus(1'b0, 8'hFF, 0, 4'hF);
		check(rd, 32'h0);
		bus(1'b0, 8'h71, 0, 4'hF);
		check(rd, 32'h0);
		// random trim writes, a masked write must not land
		for (int k = 0; k < 12; k++) begin
			ofs = trim_ofs(k % 4);
			w = 8'($random(seed));
			bus(1'b1, ofs, {24'h0, w}, 4'hF);
			bus(1'b1, ofs, {24'h0, ~w}, 4'hE);
			bus(1'b0, ofs, 0, 4'hF);
			check(rd, {24'h0, w});
			exp_v = (ofs == 8'h7C) ? {28'h0, w[3:0]} : {24'h0, w};
			check(pin_of(ofs), exp_v);
		end
		// frozen clock enable: a write is neither taken nor answered
		ce <= 1'b0;
		avs_address <= {8'h7E, 2'b00};
		avs_writedata <= {24'h0, ~w};
		avs_byteenable <= 4'hF;
		avs_write <= 1'b1;
		repeat (4) @(posedge clock);
		check({31'h0, avs_waitrequest}, 32'h1);
		avs_write <= 1'b0;
		ce <= 1'b1;
		@(posedge clock);
		bus(1'b0, 8'h7E, 0, 4'hF);
		check(rd, {24'h0, w});
		// full vector restore streamed at one address while halted
		bus(1'b1, 8'h70, 32'h1, 4'hF);
		for (int i = 0; i < 673; i++) begin
			vec[i] = (i == 0) ? 8'hFF : (i == 672) ? 8'h00 : 8'($random(seed));
			bus(1'b1, 8'h71, {24'h0, vec[i]}, 4'hF);
			if (i == 671) begin
				check({31'h0, vec_valid}, 32'h0);
			end
		end
		check({31'h0, vec_valid}, 32'h1);
		for (int i = 0; i < 673; i++) begin
			bus(1'b0, 8'h71, 0, 4'hF);
			check(rd, {24'h0, vec[i]});
		end
		bus(1'b0, 8'h73, 0, 4'hF);
		check(rd, 32'h0);
		// partial pass after restart leaves vector invalid
		bus(1'b1, 8'h70, 32'h0, 4'hF);
		bus(1'b1, 8'h70, 32'h1, 4'hF);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'h71, 0, 4'hF);
			check(rd, {24'h0, vec[i]});
		end
		check({31'h0, vec_valid}, 32'h0);
		bus(1'b0, 8'h73, 0, 4'hF);
		check(rd, 32'h5);
		// status: halted, vector invalid after the cut pass, no misuse
		bus(1'b0, 8'h72, 0, 4'hF);
		check(rd, 32'h1);
		// a data access while calibration runs is flagged
		halted <= 1'b0;
		repeat (5) @(posedge clock);
		bus(1'b0, 8'h71, 0, 4'hF);
		check(rd, {24'h0, vec[5]});
		bus(1'b0, 8'h72, 0, 4'hF);
		check(rd, 32'h4);
		close_out();
	end
endmodule : tb
